// ### rjb_params.svh
// Purpose: Opcode fields, offsets and constants for the register-jump and load unit
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes:   Definitions only
`ifndef RJB_PARAMS_SVH
`define RJB_PARAMS_SVH
`define RJB_OP_FUNC_GROUP 6'h00
`define RJB_FN_JUMP_REG   6'h08
`define RJB_FN_JUMP_LINK  6'h09
`define RJB_OP_LD_SBYTE   6'h20
`define RJB_OP_LD_UBYTE   6'h24
`define RJB_OP_LD_DWORD   6'h37
`define RJB_OP_LD_COP     4'hd
`define RJB_LINK_OFFSET   64'h0000_0000_0000_0008
`define RJB_LINK_REG_DFLT 5'h1f
`define RJB_OP_MSB        31
`define RJB_SRC_MSB       25
`define RJB_TGT_MSB       20
`define RJB_DST_MSB       15
`define RJB_IMM_MSB       15
`endif

// ### rjb_pkg.sv
// Purpose: Shared types for the register-jump and load unit
// Assumes: Nothing beyond the parameter header
// Notes:   States are Gray coded
package rjb_pkg;
    typedef enum logic [0:0] {
        RJB_ST_IDLE = 1'b0,
        RJB_ST_WAIT = 1'b1
    } rjb_state_t;

    typedef enum logic [2:0] {
        RJB_EXC_NONE      = 3'h0,
        RJB_EXC_TLB_REFIL = 3'h1,
        RJB_EXC_TLB_INVAL = 3'h2,
        RJB_EXC_BUS_ERR   = 3'h3,
        RJB_EXC_ADDR_ERR  = 3'h4,
        RJB_EXC_RESV_INST = 3'h5,
        RJB_EXC_COP_UNUSE = 3'h6
    } rjb_exc_t;

    typedef enum logic [1:0] {
        RJB_LD_SBYTE = 2'h0,
        RJB_LD_UBYTE = 2'h1,
        RJB_LD_DWORD = 2'h2,
        RJB_LD_COP   = 2'h3
    } rjb_load_t;
endpackage

// ### rjb_byte_lane.sv
// Purpose: Pick one byte out of a fetched doubleword and extend it
// Assumes: Address bits are the virtual ones, not the endian-flipped physical ones
// Notes:   Combinational
module rjb_byte_lane #(
    parameter int LANE_BITS = 3
) (
    // Data
    input  wire logic [63:0]          dword_in,
    input  wire logic [LANE_BITS-1:0] addr_in,
    // Mode
    input  wire logic                 big_endian_in,
    input  wire logic                 sign_in,
    // Result
    output logic      [63:0]          value_out
);
    if (LANE_BITS != 2 && LANE_BITS != 3) begin : g_bad_lanes
        $error("rjb_byte_lane: LANE_BITS must be 2 or 3");
    end

    wire logic [LANE_BITS-1:0] lane_idx = addr_in ^ {LANE_BITS{big_endian_in}};
    wire logic [7:0]           lane_byte = dword_in[{3'h0, lane_idx} * 8 +: 8];
    wire logic                 fill_bit  = sign_in & lane_byte[7];

    assign value_out = {{56{fill_bit}}, lane_byte};
endmodule // rjb_byte_lane

// ### rjb_exec.sv
// Purpose: Execute register jumps and byte, doubleword and coprocessor doubleword loads
// Assumes: Operand value of the source/base register arrives with the instruction
// Notes:   One load in flight; instructions offered while busy are ignored
// Functional notes
// - Linked register jump writes its own address plus 8 to the destination.
// - Both jump forms run the delay-slot instruction, then fetch at the target.
// - Only the linked register jump takes its link register from a field.
// - Jump reads its target before the link write, so re-execution works.
// - Misaligned jump target faults at fetch, never on the jump itself.
// - Signed byte load sign-extends the addressed byte into the target register.
// - Unsigned byte load zero-fills the upper bits of the target register.
// - Byte loads raise only refill, invalid and address-error exceptions; the code raises only refill and invalid on them.
// - Doubleword load with any low three address bits set raises address error.
// - Doubleword load writes the aligned 64-bit doubleword unchanged.
// - Doubleword load may raise refill, invalid, bus, address, reserved errors.
// - Coprocessor doubleword load hands data to the unit named by opcode.
// - Coprocessor load raises coprocessor-unusable when its usable bit is clear.
// - Coprocessor load with any low three address bits set raises address error.
`include "rjb_params.svh"
module rjb_exec
    import rjb_pkg::*;
#(
    parameter int LANE_BITS = 3
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Instruction stream
    input  wire logic        instr_valid_in,
    input  wire logic [31:0] instr_in,
    input  wire logic [63:0] pc_in,
    input  wire logic [63:0] src_val_in,
    input  wire logic        slot_exc_in,
    // Mode
    input  wire logic        cpu_big_endian_mode_in,
    input  wire logic        user_endian_flip_in,
    input  wire logic        ext64_en_in,
    input  wire logic [3:0]  cop_usable_in,
    // Data memory answer
    input  wire logic        mem_ack_in,
    input  wire logic [63:0] mem_rdata_in,
    input  wire logic        mem_tlb_refill_in,
    input  wire logic        mem_tlb_invalid_in,
    input  wire logic        mem_bus_err_in,
    // Data memory request
    output logic             busy_out,
    output logic             mem_req_out,
    output logic [63:0]      mem_addr_out,
    output logic             mem_dword_out,
    // General register write
    output logic             gpr_we_out,
    output logic [4:0]       gpr_idx_out,
    output logic [63:0]      gpr_data_out,
    // Coprocessor write
    output logic             cop_we_out,
    output logic [1:0]       cop_num_out,
    output logic [4:0]       cop_reg_out,
    output logic [63:0]      cop_data_out,
    // Exceptions and fetch redirect
    output logic             exc_out,
    output rjb_exc_t         exc_code_out,
    output logic             redirect_out,
    output logic [63:0]      redirect_pc_out,
    output logic             fetch_addr_err_out
);
    if (LANE_BITS != 2 && LANE_BITS != 3) begin : g_bad_lanes
        $error("rjb_exec: LANE_BITS must be 2 or 3");
    end

    rjb_state_t state_r;
    rjb_load_t  kind_r;
    logic [LANE_BITS-1:0] lane_r;
    logic       pend_r;
    logic [63:0] pend_tgt_r;

    // Decode
    wire logic [5:0]  op_f   = instr_in[`RJB_OP_MSB -: 6];
    wire logic [5:0]  fn_f   = instr_in[5:0];
    wire logic [4:0]  rt_f   = instr_in[`RJB_TGT_MSB -: 5];
    wire logic [4:0]  rd_f   = instr_in[`RJB_DST_MSB -: 5];
    wire logic        take   = instr_valid_in && state_r == RJB_ST_IDLE;
    wire logic        is_fg  = op_f == `RJB_OP_FUNC_GROUP;
    wire logic        is_jr  = take && is_fg && fn_f == `RJB_FN_JUMP_REG;
    wire logic        is_jl  = take && is_fg && fn_f == `RJB_FN_JUMP_LINK;
    wire logic        is_lb  = take && op_f == `RJB_OP_LD_SBYTE;
    wire logic        is_lbu = take && op_f == `RJB_OP_LD_UBYTE;
    wire logic        is_ld  = take && op_f == `RJB_OP_LD_DWORD;
    wire logic [1:0]  cop_z  = op_f[1:0];
    // Unit 3 shares its opcode with the doubleword load, so it is not a coprocessor load
    wire logic        is_ldc = take && op_f[5:2] == `RJB_OP_LD_COP && cop_z != 2'h0
                               && op_f != `RJB_OP_LD_DWORD;
    wire logic        is_ldx = is_ld || is_ldc;
    wire logic        is_load = is_lb || is_lbu || is_ldx;

    // Address and checks
    wire logic [63:0] ea = src_val_in
                           + {{48{instr_in[`RJB_IMM_MSB]}}, instr_in[`RJB_IMM_MSB:0]};
    wire logic        mis_dw = ea[2:0] != 3'h0;
    wire logic        ri_err = is_ld && !ext64_en_in;
    wire logic        cu_err = is_ldc && !cop_usable_in[cop_z];
    wire logic        ae_err = is_ldx && mis_dw;
    wire logic        pre_err = ri_err || cu_err || ae_err;
    wire rjb_exc_t    pre_code = ri_err ? RJB_EXC_RESV_INST
                               : cu_err ? RJB_EXC_COP_UNUSE : RJB_EXC_ADDR_ERR;
    // A 32-bit datapath flips only the two low address bits
    wire logic [2:0]  flip3  = {user_endian_flip_in && LANE_BITS == 3, {2{user_endian_flip_in}}};
    wire logic [63:0] phys_ea = is_ldx ? ea : {ea[63:3], ea[2:0] ^ flip3};
    wire rjb_load_t   kind_d = is_lb ? RJB_LD_SBYTE : is_lbu ? RJB_LD_UBYTE
                             : is_ld ? RJB_LD_DWORD : RJB_LD_COP;

    // Memory answer
    wire logic        ack    = state_r == RJB_ST_WAIT && mem_ack_in;
    wire logic        is_byte = kind_r == RJB_LD_SBYTE || kind_r == RJB_LD_UBYTE;
    // Byte loads cannot see a bus error; it is dropped rather than reported
    wire logic        r_bus  = mem_bus_err_in && !is_byte;
    wire logic        r_err  = mem_tlb_refill_in || mem_tlb_invalid_in || r_bus;
    wire rjb_exc_t    r_code = mem_tlb_refill_in ? RJB_EXC_TLB_REFIL
                             : mem_tlb_invalid_in ? RJB_EXC_TLB_INVAL : RJB_EXC_BUS_ERR;
    wire logic [63:0] byte_val;

    rjb_byte_lane #(.LANE_BITS(LANE_BITS)) u_lane (
        .dword_in      (mem_rdata_in),
        .addr_in       (lane_r),
        .big_endian_in (cpu_big_endian_mode_in),
        .sign_in       (kind_r == RJB_LD_SBYTE),
        .value_out     (byte_val)
    );

    // Delay slot: any instruction taken while a jump is pending is the slot
    wire logic slot_done = pend_r && instr_valid_in && !busy_out;
    wire logic slot_kill = pend_r && slot_exc_in;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= RJB_ST_IDLE;
        end else if (is_load && !pre_err) begin
            state_r <= RJB_ST_WAIT;
        end else if (ack) begin
            state_r <= RJB_ST_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            kind_r <= RJB_LD_SBYTE;
            lane_r <= '0;
            cop_num_out <= 2'h0;
            cop_reg_out <= 5'h0;
        end else if (is_load) begin
            kind_r <= kind_d;
            lane_r <= ea[LANE_BITS-1:0];
            cop_num_out <= cop_z;
            cop_reg_out <= rt_f;
        end
    end

    // Jump target is captured from the source before the link is written
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pend_r <= 1'b0;
            pend_tgt_r <= 64'h0;
        end else if ((is_jr || is_jl) && !pend_r) begin
            pend_r <= 1'b1;
            pend_tgt_r <= src_val_in;
        end else if (slot_done || slot_kill) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            redirect_out <= 1'b0;
            redirect_pc_out <= 64'h0;
            fetch_addr_err_out <= 1'b0;
        end else begin
            redirect_out <= slot_done && !slot_kill;
            redirect_pc_out <= slot_done ? pend_tgt_r : redirect_pc_out;
            fetch_addr_err_out <= slot_done && !slot_kill && pend_tgt_r[1:0] != 2'h0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_req_out <= 1'b0;
            mem_addr_out <= 64'h0;
            mem_dword_out <= 1'b0;
        end else if (is_load && !pre_err) begin
            mem_req_out <= 1'b1;
            mem_addr_out <= phys_ea;
            mem_dword_out <= is_ldx;
        end else if (ack) begin
            mem_req_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gpr_we_out <= 1'b0;
            gpr_idx_out <= 5'h0;
            gpr_data_out <= 64'h0;
            cop_we_out <= 1'b0;
            cop_data_out <= 64'h0;
            exc_out <= 1'b0;
            exc_code_out <= RJB_EXC_NONE;
        end else begin
            gpr_we_out <= is_jl || (ack && !r_err && kind_r != RJB_LD_COP);
            cop_we_out <= ack && !r_err && kind_r == RJB_LD_COP;
            exc_out <= (is_load && pre_err) || (ack && r_err);
            exc_code_out <= (is_load && pre_err) ? pre_code
                          : (ack && r_err) ? r_code : RJB_EXC_NONE;
            if (is_jl) begin
                gpr_idx_out <= rd_f;
                gpr_data_out <= pc_in + `RJB_LINK_OFFSET;
            end else if (is_load) begin
                gpr_idx_out <= rt_f;
            end
            if (ack) begin
                gpr_data_out <= is_byte ? byte_val : mem_rdata_in;
                cop_data_out <= mem_rdata_in;
            end
        end
    end

    assign busy_out = state_r != RJB_ST_IDLE;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_link;
        is_jl |=> gpr_we_out && gpr_data_out == $past(pc_in) + `RJB_LINK_OFFSET;
    endproperty
    a_link: assert property (p_link) else $error("link value wrong");

    property p_slot_first;
        (is_jr || is_jl) && !pend_r |=> !redirect_out;
    endproperty
    a_slot_first: assert property (p_slot_first) else $error("redirect before slot");

    property p_link_idx;
        is_jl |=> gpr_idx_out == $past(rd_f);
    endproperty
    a_link_idx: assert property (p_link_idx) else $error("link index wrong");

    property p_tgt_kept;
        (is_jl && !pend_r) ##1 (pend_r && slot_done && !slot_kill)
            |=> redirect_out && redirect_pc_out == $past(src_val_in, 2);
    endproperty
    a_tgt_kept: assert property (p_tgt_kept) else $error("target not from source");

    property p_no_jump_fault;
        is_jr || is_jl |=> !exc_out;
    endproperty
    a_no_jump_fault: assert property (p_no_jump_fault) else $error("jump faulted");

    property p_fetch_err;
        redirect_out && redirect_pc_out[1:0] != 2'h0 |-> fetch_addr_err_out;
    endproperty
    a_fetch_err: assert property (p_fetch_err) else $error("misaligned fetch missed");

    property p_ea;
        is_load && !pre_err |=> mem_req_out
            && mem_addr_out[63:3] == $past(ea[63:3]);
    endproperty
    a_ea: assert property (p_ea) else $error("address wrong");

    property p_sext;
        ack && !r_err && kind_r == RJB_LD_SBYTE
            |=> gpr_data_out[63:8] == {56{gpr_data_out[7]}};
    endproperty
    a_sext: assert property (p_sext) else $error("sign fill wrong");

    property p_zext;
        ack && !r_err && kind_r == RJB_LD_UBYTE |=> gpr_data_out[63:8] == 56'h0;
    endproperty
    a_zext: assert property (p_zext) else $error("zero fill wrong");

    property p_dw_align;
        is_ldx && mis_dw |=> exc_out && !mem_req_out;
    endproperty
    a_dw_align: assert property (p_dw_align) else $error("misaligned load ran");

    property p_cop_unuse;
        is_ldc && !cop_usable_in[cop_z] |=> exc_out && exc_code_out == RJB_EXC_COP_UNUSE;
    endproperty
    a_cop_unuse: assert property (p_cop_unuse) else $error("usable check missed");

    property p_cop_dest;
        cop_we_out |-> !gpr_we_out;
    endproperty
    a_cop_dest: assert property (p_cop_dest) else $error("cop data to gpr");

    c_jl: cover property (is_jl ##1 slot_done ##1 redirect_out);
    c_lb: cover property (ack && kind_r == RJB_LD_SBYTE ##1 gpr_we_out);
    c_ldc: cover property (ack && kind_r == RJB_LD_COP ##1 cop_we_out);
endmodule // rjb_exec

// ### rjb_mem_model.sv
// Purpose: Data memory stand-in for the register-jump and load unit
// Assumes: One request at a time, held until acknowledged
// Notes:   Answer delay and error flag are set by the bench
module rjb_mem_model #(
    parameter logic [63:0] DATA = 64'h0
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Control from bench
    input  wire logic [3:0]  delay_in,
    input  wire logic [1:0]  err_in,
    // Request side
    input  wire logic        req_in,
    output logic             ack_out,
    output logic [63:0]      rdata_out,
    output logic             refill_out,
    output logic             invalid_out,
    output logic             bus_err_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    logic       done_r;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r   <= 4'h0;
            done_r  <= 1'b0;
            ack_out <= 1'b0;
        end else begin
            ack_out <= 1'b0;
            if (!req_in) begin
                cnt_r  <= 4'h0;
                done_r <= 1'b0;
            end else if (!done_r && !ack_out) begin
                if (cnt_r >= delay_in) begin
                    ack_out <= 1'b1;
                    done_r  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
    // Whole aligned doubleword; inverted when idle so stale data never looks valid
    assign rdata_out   = ack_out ? DATA : ~DATA;
    assign refill_out  = ack_out && (err_in == 2'h1);
    assign invalid_out = ack_out && (err_in == 2'h2);
    assign bus_err_out = ack_out && (err_in == 2'h3);
endmodule // rjb_mem_model

// ### register_jump_and_byte_load_exec_tb_top.sv
// Purpose: Self-checking bench for the register-jump and load unit
// Assumes: Inputs change at the falling edge
// Notes:   Memory data is one fixed pattern with mixed byte signs
`include "rjb_params.svh"
module register_jump_and_byte_load_exec_tb_top
    import rjb_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] PAT = 64'hf1e2_d3c4_3526_1708;
    logic clk_in = 1'b0;
    logic resetn_in, instr_valid_in, slot_exc_in, cpu_big_endian_mode_in;
    logic user_endian_flip_in, ext64_en_in, mem_ack_in, refill, invalid, bus_err;
    logic [3:0] cop_usable_in, dly_sel;
    logic [1:0] err_sel;
    logic [31:0] instr_in;
    logic [63:0] pc_in, src_val_in, mem_rdata_in, mem_addr_out, gpr_data_out, cop_data_out;
    logic [63:0] redirect_pc_out, req_addr, res_data;
    logic busy_out, mem_req_out, mem_dword_out, gpr_we_out, cop_we_out, exc_out;
    logic redirect_out, fetch_addr_err_out, req_dw, req_busy, req_seen;
    logic [4:0] gpr_idx_out, cop_reg_out, res_idx;
    logic [1:0] cop_num_out, res_num;
    logic [2:0] res_code;
    rjb_exc_t exc_code_out;
    int errors = 0, cmp_count = 0, cyc = 0, got_kind;

    always #50 clk_in = ~clk_in;

    rjb_exec #(.LANE_BITS(3)) i_rjb_exec (.clk_in(clk_in), .resetn_in(resetn_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .pc_in(pc_in),
        .src_val_in(src_val_in), .slot_exc_in(slot_exc_in),
        .cpu_big_endian_mode_in(cpu_big_endian_mode_in),
        .user_endian_flip_in(user_endian_flip_in), .ext64_en_in(ext64_en_in),
        .cop_usable_in(cop_usable_in), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
        .mem_tlb_refill_in(refill), .mem_tlb_invalid_in(invalid), .mem_bus_err_in(bus_err),
        .busy_out(busy_out), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
        .mem_dword_out(mem_dword_out), .gpr_we_out(gpr_we_out), .gpr_idx_out(gpr_idx_out),
        .gpr_data_out(gpr_data_out), .cop_we_out(cop_we_out), .cop_num_out(cop_num_out),
        .cop_reg_out(cop_reg_out), .cop_data_out(cop_data_out), .exc_out(exc_out),
        .exc_code_out(exc_code_out), .redirect_out(redirect_out),
        .redirect_pc_out(redirect_pc_out), .fetch_addr_err_out(fetch_addr_err_out));

    rjb_mem_model #(.DATA(PAT)) i_rjb_mem_model (.clk_in(clk_in), .resetn_in(resetn_in),
        .delay_in(dly_sel), .err_in(err_sel), .req_in(mem_req_out), .ack_out(mem_ack_in),
        .rdata_out(mem_rdata_in), .refill_out(refill), .invalid_out(invalid),
        .bus_err_out(bus_err));

    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Loads take a handful of cycles each; this is far beyond the whole run
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] t,
                                       input logic [15:0] im);
        return {op, 5'h2, t, im};
    endfunction

    task automatic drive(input logic v, input logic [31:0] i, input logic [63:0] p, s);
        @(negedge clk_in);
        instr_valid_in = v;
        instr_in = i;
        pc_in = p;
        src_val_in = s;
    endtask

    // Offer one load and wait, bounded, for its single result pulse
    task automatic run_ld(input logic [31:0] ins, input logic [63:0] base);
        got_kind = 0;
        req_seen = 1'b0;
        res_code = 3'h0;
        drive(1'b1, ins, 64'h4000, base);
        drive(1'b0, ins, 64'h4000, base);
        for (int n = 0; n < 20 && got_kind == 0; n++) begin
            if (mem_req_out === 1'b1) begin
                req_seen = 1'b1;
                req_addr = mem_addr_out;
                req_dw = mem_dword_out;
                req_busy = busy_out;
            end
            if (gpr_we_out === 1'b1) begin
                got_kind = 1;
                res_data = gpr_data_out;
                res_idx = gpr_idx_out;
            end
            if (cop_we_out === 1'b1) begin
                got_kind = 2;
                res_data = cop_data_out;
                res_idx = cop_reg_out;
                res_num = cop_num_out;
            end
            if (exc_out === 1'b1) begin
                got_kind = 3;
                res_code = exc_code_out;
            end
            if (got_kind == 0) @(negedge clk_in);
        end
    endtask

    task automatic t_jump(input logic [31:0] ins, input logic [63:0] tgt, input logic sx,
                          input logic lnk);
        drive(1'b1, ins, 64'h8000, tgt);
        drive(1'b1, 32'h0, 64'h8004, 64'h0);
        slot_exc_in = sx;
        chk("link_we", lnk, gpr_we_out);
        if (lnk) chk("link_idx", 5'h7, gpr_idx_out);
        if (lnk) chk("link_data", 64'h8008, gpr_data_out);
        drive(1'b0, 32'h0, 64'h8008, 64'h0);
        slot_exc_in = 1'b0;
        chk("redirect", !sx, redirect_out);
        if (!sx) chk("target", tgt, redirect_pc_out);
        chk("fetch_err", !sx && (tgt[1:0] != 2'h0), fetch_addr_err_out);
        $display("t_jump done");
    endtask

    task automatic t_bytes;
        logic [2:0] a, ln;
        logic [7:0] b;
        for (int k = 0; k < 8; k++) begin
            a = k[2:0];
            cpu_big_endian_mode_in = a[1];
            user_endian_flip_in = a[2];
            run_ld(mk(a[0] ? `RJB_OP_LD_UBYTE : `RJB_OP_LD_SBYTE, 5'h9, {13'h1ffe, a}), 64'h2000);
            ln = a ^ {3{a[1]}};
            b = PAT[8*ln +: 8];
            chk("lb_addr", {61'h3fe, a ^ {3{a[2]}}}, req_addr);
            chk("lb_dw", 1'b0, req_dw);
            chk("lb_idx", 5'h9, res_idx);
            chk("lb_data", a[0] ? {56'h0, b} : {{56{b[7]}}, b}, res_data);
        end
        cpu_big_endian_mode_in = 1'b0;
        user_endian_flip_in = 1'b0;
        $display("t_bytes done");
    endtask

    task automatic t_dword;
        // Unit 3 unusable must not disturb the doubleword load sharing its opcode
        cop_usable_in = 4'h7;
        run_ld(mk(`RJB_OP_LD_DWORD, 5'h5, 16'hfff8), 64'h3008);
        cop_usable_in = 4'hf;
        chk("ld_kind", 1, 64'(got_kind));
        chk("ld_data", PAT, res_data);
        chk("ld_addr", 64'h3000, req_addr);
        chk("ld_dw", 1'b1, req_dw);
        run_ld(mk(`RJB_OP_LD_DWORD, 5'h5, 16'h0), 64'h3004);
        chk("ld_mis", RJB_EXC_ADDR_ERR, res_code);
        chk("ld_noreq", 1'b0, req_seen);
        ext64_en_in = 1'b0;
        run_ld(mk(`RJB_OP_LD_DWORD, 5'h5, 16'h0), 64'h3000);
        ext64_en_in = 1'b1;
        chk("ld_resv", RJB_EXC_RESV_INST, res_code);
        for (int e = 1; e < 4; e++) begin
            err_sel = e[1:0];
            run_ld(mk(`RJB_OP_LD_SBYTE, 5'h6, 16'h0), 64'h3000);
            chk("lb_err_kind", (e == 3) ? 1 : 3, 64'(got_kind));
            if (e < 3) chk("lb_err", 64'(e), res_code);
            run_ld(mk(`RJB_OP_LD_DWORD, 5'h6, 16'h0), 64'h3000);
            chk("ld_err", 64'(e), res_code);
        end
        err_sel = 2'h0;
        $display("t_dword done");
    endtask

    task automatic t_cop;
        dly_sel = 4'h3;
        for (int z = 1; z < 3; z++) begin
            run_ld(mk({4'hd, z[1:0]}, 5'h11, 16'h8), 64'h3000);
            chk("cop_kind", 2, 64'(got_kind));
            chk("cop_num", z[1:0], res_num);
            chk("cop_reg", 5'h11, res_idx);
            chk("cop_data", PAT, res_data);
            chk("cop_addr", 64'h3008, req_addr);
            chk("cop_busy", 1'b1, req_busy);
        end
        dly_sel = 4'h0;
        cop_usable_in = 4'hb;
        run_ld(mk(6'h36, 5'h11, 16'h8), 64'h3000);
        cop_usable_in = 4'hf;
        chk("cop_unuse", RJB_EXC_COP_UNUSE, res_code);
        chk("cop_noreq", 1'b0, req_seen);
        run_ld(mk(6'h35, 5'h11, 16'h4), 64'h3000);
        chk("cop_mis", RJB_EXC_ADDR_ERR, res_code);
        $display("t_cop done");
    endtask

    initial begin
        resetn_in = 1'b0;
        instr_valid_in = 1'b0;
        instr_in = 32'h0;
        pc_in = 64'h0;
        src_val_in = 64'h0;
        slot_exc_in = 1'b0;
        cpu_big_endian_mode_in = 1'b0;
        user_endian_flip_in = 1'b0;
        ext64_en_in = 1'b1;
        cop_usable_in = 4'hf;
        dly_sel = 4'h0;
        err_sel = 2'h0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        resetn_in = 1'b1;
        t_jump({6'h0, 5'h3, 5'h0, 5'h7, 5'h0, `RJB_FN_JUMP_LINK}, 64'h9002, 1'b0, 1'b1);
        t_jump({6'h0, 5'h4, 15'h0, `RJB_FN_JUMP_REG}, 64'ha000, 1'b1, 1'b0);
        t_jump({6'h0, 5'h4, 15'h0, `RJB_FN_JUMP_REG}, 64'ha004, 1'b0, 1'b0);
        t_bytes();
        t_dword();
        t_cop();
        close_out();
    end
endmodule // register_jump_and_byte_load_exec_tb_top
